// [rtl/fcs_map.svh]
// constants for the flash command and status unit
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_READ_IDENT 8'h90
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_ERASE_SETUP 8'h20
`define FCS_CMD_CONFIRM 8'hd0
`define FCS_CMD_PROG_SETUP_A 8'h40
`define FCS_CMD_PROG_SETUP_B 8'h10
`define FCS_CMD_SUSPEND 8'hb0
`define FCS_BIT_READY 7
`define FCS_BIT_ERASE_PAUSED 6
`define FCS_BIT_ERASE_FAIL 5
`define FCS_BIT_PROG_FAIL 4
`define FCS_BIT_VPP_LOW 3
`define FCS_BIT_PROG_PAUSED 2
`define FCS_BIT_LOCK_ABORT 1
`define FCS_BIT_RESERVED 0
`define FCS_ERR_MASK 8'h3a
`define FCS_IDENT_MAKER_ADDR 1'h0
`define FCS_IDENT_MAKER 8'h5a
`define FCS_IDENT_DEVICE 8'ha5
`define FCS_CLR_MASK 8'h01
`endif

// [rtl/fcs_pkg.sv]
// types for the flash command and status unit
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_RD_ARRAY,
    FCS_RD_IDENT,
    FCS_RD_STATUS
  } fcs_read_e;
  typedef enum logic [1:0] {
    FCS_SEQ_IDLE,
    FCS_SEQ_ERASE,
    FCS_SEQ_PROG
  } fcs_seq_e;
  typedef enum logic [1:0] {
    FCS_OP_NONE,
    FCS_OP_ERASE,
    FCS_OP_PROG
  } fcs_op_e;
endpackage

// [rtl/fcs_read_mux.sv]
// read data selector for array, identifier and status reads
`timescale 1ns/100ps
`default_nettype none
`include "fcs_map.svh"
module fcs_read_mux (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // selection
  input wire fcs_pkg::fcs_read_e i_mode,
  input wire logic i_rd,
  input wire logic i_ident_address,
  input wire logic [7:0] i_array_data,
  input wire logic [7:0] i_status,
  // result
  output logic [7:0] o_rdata
);
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_mode)
        fcs_pkg::FCS_RD_IDENT: begin
          o_rdata <= (i_ident_address == `FCS_IDENT_MAKER_ADDR) ?
            `FCS_IDENT_MAKER : `FCS_IDENT_DEVICE;
        end
        fcs_pkg::FCS_RD_STATUS: begin
          o_rdata <= i_status;
        end
        default: begin
          o_rdata <= i_array_data;
        end
      endcase
    end
  end
endmodule // fcs_read_mux
`default_nettype wire

// [rtl/fcs_unit.sv]
// command decoder and status register of a byte-wide flash
//
// Functional notes
// - low program voltage: reads still served, no program or erase starts
// - erase or program succeeds only with high program voltage present
// - 90h enters identifier mode; reads return maker or device code by address
// - 70h enters status mode; every read returns the status byte
// - FFh array read, 50h clears flags, B0h suspends, D0h resumes
// - erase is 20h then D0h in the block; starts only after confirm
// - 40h or 10h as first write sets up a byte program
// - second program write gives address and data; device programs it
// - erase or program on a locked block fails, array untouched, reported
// - status bit 7 is 0 while busy, 1 when ready
// - bits 6..0 meaningless while bit 7 is 0
// - status bit 6 is 1 while an erase is suspended
// - status bit 5 set when an erase fails
// - status bit 4 set when a program fails
// - bad erase sequence sets both bits 5 and 4
// - bit 3 records voltage low seen by an operation, not continuously
// - status bit 2 is 1 while a program is suspended
// - bit 1 set when lock bit or protect pin aborted an operation
// - bit 0 reserved, reads 0
// - after reset the decoder is in array-read mode
// - after an operation starts, reads return status until new command
// - array-read command ignored while an unsuspended operation runs
// - error flags set by refused commands and engine failures, cleared by clear-status or reset
`timescale 1ns/100ps
`default_nettype none
`include "fcs_map.svh"
module fcs_unit (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // host bus cycles
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [21:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // array side
  input wire logic [7:0] i_array_data,
  input wire logic i_block_locked,
  input wire logic i_top_block_protect_n,
  input wire logic i_in_top_block,
  input wire logic i_write_protect_n,
  input wire logic i_prog_voltage_high_level,
  input wire logic i_prog_voltage_lockout_level,
  // write engine
  input wire logic i_engine_done,
  input wire logic i_engine_fail,
  input wire logic i_engine_paused,
  output logic o_start_erase,
  output logic o_start_prog,
  output logic [21:0] o_program_target_address,
  output logic [7:0] o_program_write_value,
  output logic o_suspend_req,
  output logic o_resume_req,
  output logic o_engine_ready_flag
);
  fcs_pkg::fcs_read_e read_mode_q;
  fcs_pkg::fcs_seq_e seq_q;
  fcs_pkg::fcs_op_e op_q;
  logic busy_q;
  logic erase_paused_q;
  logic program_paused_q;
  logic [7:0] err_q;
  logic [7:0] operation_status;
  logic protected_blk;
  logic cmd_prog_setup;
  logic running;

  function automatic logic is_prog_setup(input logic [7:0] d);
    is_prog_setup = (d == `FCS_CMD_PROG_SETUP_A) || (d == `FCS_CMD_PROG_SETUP_B);
  endfunction

  assign cmd_prog_setup = is_prog_setup(i_wdata);
  // pins sampled at the start; lock aborts, as does the top-block pin in the top block or the write-protect pin elsewhere
  assign protected_blk = i_block_locked ||
    (i_in_top_block ? !i_top_block_protect_n : !i_write_protect_n);
  assign running = busy_q && !erase_paused_q && !program_paused_q;

  // bit 0 reserved; bits 6..0 only meaningful once ready
  always_comb begin
    operation_status = err_q;
    operation_status[`FCS_BIT_READY] = !busy_q || erase_paused_q || program_paused_q;
    operation_status[`FCS_BIT_ERASE_PAUSED] = erase_paused_q;
    operation_status[`FCS_BIT_PROG_PAUSED] = program_paused_q;
  end

  // start conditions for a second write: D0h confirm for erase, any data byte for program
  logic go_erase;
  logic go_prog;
  logic start_ok;
  assign start_ok = !protected_blk && !i_prog_voltage_lockout_level &&
    i_prog_voltage_high_level;
  assign go_erase = i_wr && seq_q == fcs_pkg::FCS_SEQ_ERASE &&
    i_wdata == `FCS_CMD_CONFIRM && start_ok;
  assign go_prog = i_wr && seq_q == fcs_pkg::FCS_SEQ_PROG && start_ok;

  // two-write sequence tracking
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      seq_q <= fcs_pkg::FCS_SEQ_IDLE;
    end else if (i_wr) begin
      if (seq_q != fcs_pkg::FCS_SEQ_IDLE) begin
        seq_q <= fcs_pkg::FCS_SEQ_IDLE;
      end else if (i_wdata == `FCS_CMD_ERASE_SETUP && !busy_q) begin
        // erase only from idle; a suspended erase accepts a program only
        seq_q <= fcs_pkg::FCS_SEQ_ERASE;
      end else if (cmd_prog_setup && (!busy_q || erase_paused_q)) begin
        seq_q <= fcs_pkg::FCS_SEQ_PROG;
      end
    end
  end

  // read mode selection
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      read_mode_q <= fcs_pkg::FCS_RD_ARRAY;
    end else if (i_wr) begin
      if (seq_q != fcs_pkg::FCS_SEQ_IDLE) begin
        read_mode_q <= fcs_pkg::FCS_RD_STATUS;
      end else begin
        case (i_wdata)
          `FCS_CMD_READ_ARRAY: begin
            if (!running) begin
              read_mode_q <= fcs_pkg::FCS_RD_ARRAY;
            end
          end
          `FCS_CMD_READ_IDENT: begin
            read_mode_q <= fcs_pkg::FCS_RD_IDENT;
          end
          `FCS_CMD_READ_STATUS, `FCS_CMD_SUSPEND, `FCS_CMD_CONFIRM: begin
            read_mode_q <= fcs_pkg::FCS_RD_STATUS;
          end
          default: begin
            read_mode_q <= read_mode_q;
          end
        endcase
      end
    end
  end

  // engine busy, operation kind and suspend states
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      busy_q <= 1'b0;
      op_q <= fcs_pkg::FCS_OP_NONE;
      erase_paused_q <= 1'b0;
      program_paused_q <= 1'b0;
    end else begin
      if (go_erase || go_prog) begin
        busy_q <= 1'b1;
        op_q <= go_erase ? fcs_pkg::FCS_OP_ERASE : fcs_pkg::FCS_OP_PROG;
      end else if (i_engine_done && !i_engine_paused) begin
        busy_q <= 1'b0;
        op_q <= fcs_pkg::FCS_OP_NONE;
      end
      if (busy_q && i_engine_paused) begin
        erase_paused_q <= op_q == fcs_pkg::FCS_OP_ERASE;
        program_paused_q <= op_q == fcs_pkg::FCS_OP_PROG;
      end else if (!i_engine_paused) begin
        erase_paused_q <= 1'b0;
        program_paused_q <= 1'b0;
      end
    end
  end

  // error flags: set by refused commands and engine failures, clear by 50h; set wins
  logic [7:0] err_set;
  logic bad_confirm;
  logic attempt;
  assign bad_confirm = i_wr && seq_q == fcs_pkg::FCS_SEQ_ERASE &&
    i_wdata != `FCS_CMD_CONFIRM;
  assign attempt = i_wr && ((seq_q == fcs_pkg::FCS_SEQ_ERASE &&
    i_wdata == `FCS_CMD_CONFIRM) || seq_q == fcs_pkg::FCS_SEQ_PROG);
  always_comb begin
    err_set = 8'h00;
    if (bad_confirm) begin
      err_set[`FCS_BIT_ERASE_FAIL] = 1'b1;
      err_set[`FCS_BIT_PROG_FAIL] = 1'b1;
    end
    if (attempt && !start_ok) begin
      err_set[`FCS_BIT_LOCK_ABORT] = protected_blk;
      err_set[`FCS_BIT_VPP_LOW] = i_prog_voltage_lockout_level ||
        !i_prog_voltage_high_level;
      err_set[(seq_q == fcs_pkg::FCS_SEQ_ERASE) ? `FCS_BIT_ERASE_FAIL :
        `FCS_BIT_PROG_FAIL] = 1'b1;
    end
    if (busy_q && i_engine_done && i_engine_fail) begin
      err_set[(op_q == fcs_pkg::FCS_OP_ERASE) ? `FCS_BIT_ERASE_FAIL :
        `FCS_BIT_PROG_FAIL] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      err_q <= 8'h00;
    end else if (i_wr && seq_q == fcs_pkg::FCS_SEQ_IDLE &&
        i_wdata == `FCS_CMD_CLEAR_STATUS) begin
      err_q <= (err_set & `FCS_ERR_MASK);
    end else begin
      err_q <= (err_q | err_set) & `FCS_ERR_MASK;
    end
  end

  // engine requests, all registered
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_start_erase <= 1'b0;
      o_start_prog <= 1'b0;
      o_suspend_req <= 1'b0;
      o_resume_req <= 1'b0;
      o_program_target_address <= 22'h000000;
      o_program_write_value <= 8'h00;
      o_engine_ready_flag <= 1'b1;
    end else begin
      o_start_erase <= go_erase;
      o_start_prog <= go_prog;
      o_suspend_req <= i_wr && seq_q == fcs_pkg::FCS_SEQ_IDLE &&
        i_wdata == `FCS_CMD_SUSPEND && running;
      o_resume_req <= i_wr && seq_q == fcs_pkg::FCS_SEQ_IDLE &&
        i_wdata == `FCS_CMD_CONFIRM && (erase_paused_q || program_paused_q);
      if (go_erase || go_prog) begin
        o_program_target_address <= i_addr;
        o_program_write_value <= i_wdata;
      end
      o_engine_ready_flag <= operation_status[`FCS_BIT_READY];
    end
  end

  fcs_read_mux u_mux (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_mode(read_mode_q),
    .i_rd(i_rd),
    .i_ident_address(i_addr[0]),
    .i_array_data(i_array_data),
    .i_status(operation_status),
    .o_rdata(o_rdata)
  );

  // no start may issue under lockout voltage
  no_start_lowv_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr && i_prog_voltage_lockout_level) |=> !o_start_erase && !o_start_prog)
    else $error("start issued at low voltage");
  start_needs_high_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    $rose(o_start_prog) |-> $past(i_prog_voltage_high_level))
    else $error("program started without high voltage");
  ident_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd && read_mode_q == fcs_pkg::FCS_RD_IDENT && !i_addr[0]) |=>
    o_rdata == `FCS_IDENT_MAKER)
    else $error("maker code wrong");
  ident_device_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd && read_mode_q == fcs_pkg::FCS_RD_IDENT && i_addr[0]) |=>
    o_rdata == `FCS_IDENT_DEVICE)
    else $error("device code wrong");
  status_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd && read_mode_q == fcs_pkg::FCS_RD_STATUS) |=>
    o_rdata == $past(operation_status))
    else $error("status read wrong");
  ready_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_start_erase |-> !operation_status[`FCS_BIT_READY])
    else $error("ready while erase started");
  erase_busy_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_start_erase |=> !o_engine_ready_flag)
    else $error("ready flag high after erase start");
  reserved_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd && read_mode_q == fcs_pkg::FCS_RD_STATUS) |=> !o_rdata[`FCS_BIT_RESERVED])
    else $error("reserved bit set");
  reset_state_a: assert property (@(posedge i_mclk)
    i_srst |=> read_mode_q == fcs_pkg::FCS_RD_ARRAY && o_engine_ready_flag && err_q == 8'h00)
    else $error("reset state wrong");
  bad_confirm_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    bad_confirm |=> err_q[`FCS_BIT_ERASE_FAIL] && err_q[`FCS_BIT_PROG_FAIL] &&
    read_mode_q == fcs_pkg::FCS_RD_STATUS && !o_start_erase)
    else $error("bad confirm not flagged");
  no_array_busy_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (running && read_mode_q == fcs_pkg::FCS_RD_STATUS) |=>
    read_mode_q != fcs_pkg::FCS_RD_ARRAY)
    else $error("array mode while busy");
  err_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (err_q[`FCS_BIT_LOCK_ABORT] && !(i_wr && i_wdata == `FCS_CMD_CLEAR_STATUS)) |=>
    err_q[`FCS_BIT_LOCK_ABORT])
    else $error("error flag lost");
  prog_latch_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_start_prog |-> o_program_write_value == $past(i_wdata) &&
    o_program_target_address == $past(i_addr))
    else $error("program target not latched");
  prog_fail_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (busy_q && i_engine_done && i_engine_fail && op_q == fcs_pkg::FCS_OP_PROG) |=>
    err_q[`FCS_BIT_PROG_FAIL])
    else $error("program failure not flagged");
  lock_abort_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr && seq_q == fcs_pkg::FCS_SEQ_PROG && protected_blk) |=>
    !o_start_prog && err_q[`FCS_BIT_LOCK_ABORT] && err_q[`FCS_BIT_PROG_FAIL])
    else $error("locked program not refused");
  resume_req_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr && seq_q == fcs_pkg::FCS_SEQ_IDLE && i_wdata == `FCS_CMD_CONFIRM &&
    erase_paused_q) |=> o_resume_req)
    else $error("resume not requested");
endmodule // fcs_unit
`default_nettype wire

// [testbench/fcs_engine_model.sv]
// behavioural write engine answering start, suspend and resume
`timescale 1ns/100ps
`default_nettype none
module fcs_engine_model #(
  parameter int DUR = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // requests from the unit
  input wire logic i_start,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_fail_next,
  // answers
  output logic o_done,
  output logic o_fail,
  output logic o_paused
);
  int cnt_q;
  always_ff @(posedge i_mclk) begin
    o_done <= 1'b0;
    // fail means nothing outside done, so it wanders
    o_fail <= ~o_fail;
    if (i_srst) begin
      cnt_q <= 0;
      o_paused <= 1'b0;
      o_fail <= 1'b0;
    end else if (i_start) begin
      cnt_q <= DUR;
    end else if (i_suspend && cnt_q > 0) begin
      o_paused <= 1'b1;
    end else if (i_resume) begin
      o_paused <= 1'b0;
    end else if (cnt_q > 0 && !o_paused) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        o_done <= 1'b1;
        o_fail <= i_fail_next;
      end
    end
  end
endmodule // fcs_engine_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the flash command and status unit
`timescale 1ns/100ps
`default_nettype none
`include "fcs_map.svh"
module tb_top;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [21:0] i_addr = 22'h000000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_array_data = 8'h3c;
  logic lock = 1'b0;
  logic tbp_n = 1'b1;
  logic in_top = 1'b0;
  logic wp_n = 1'b1;
  logic vpp_hi = 1'b1;
  logic vpp_lk = 1'b0;
  logic fail_next = 1'b0;
  logic done, efail, paused, st_e, st_p, susp, resm, rdy;
  logic [21:0] tgt;
  logic [7:0] wval, rdata;
  int mismatches = 0;
  int n_compared = 0;
  int n_st = 0;
  int n_sr = 0;
  fcs_unit fcs_unit_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rdata), .i_array_data(i_array_data),
    .i_block_locked(lock), .i_top_block_protect_n(tbp_n), .i_in_top_block(in_top),
    .i_write_protect_n(wp_n), .i_prog_voltage_high_level(vpp_hi),
    .i_prog_voltage_lockout_level(vpp_lk), .i_engine_done(done), .i_engine_fail(efail),
    .i_engine_paused(paused), .o_start_erase(st_e), .o_start_prog(st_p),
    .o_program_target_address(tgt), .o_program_write_value(wval), .o_suspend_req(susp),
    .o_resume_req(resm), .o_engine_ready_flag(rdy));
  fcs_engine_model fcs_engine_model_inst (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_start(st_e | st_p), .i_suspend(susp), .i_resume(resm), .i_fail_next(fail_next),
    .o_done(done), .o_fail(efail), .o_paused(paused));
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  // every start pulse, erase or program
  always @(posedge i_mclk) begin
    if (st_e === 1'b1 || st_p === 1'b1) n_st++;
    if (susp === 1'b1 || resm === 1'b1) n_sr++;
  end
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) bad($sformatf("byte %h, wanted %h", got, exp));
  endtask
  task automatic chka(input logic [21:0] got, input logic [21:0] exp);
    n_compared++;
    if (got !== exp) bad($sformatf("address %h, wanted %h", got, exp));
  endtask
  // one write cycle carrying a command code or a program data byte
  task automatic wr(input logic [7:0] d, input logic [21:0] a = 22'h000010);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_wdata <= d;
    i_addr <= a;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    chk8(rdata, e, m);
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    repeat (2) @(posedge i_mclk);
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (rdy !== 1'b1 && k < 200);
    if (rdy !== 1'b1) begin
      bad("engine never ready");
      close_out();
    end
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(22'h000100, 8'h3c);
    chk8({7'h00, rdy}, 8'h01, 8'hff);
    wr(`FCS_CMD_READ_IDENT);
    rd(22'h000000, `FCS_IDENT_MAKER);
    rd(22'h000001, `FCS_IDENT_DEVICE);
    wr(`FCS_CMD_READ_STATUS);
    rd(22'h000001, 8'h80);
    $display("test reads done");
    wr(`FCS_CMD_READ_ARRAY);
    wr(`FCS_CMD_ERASE_SETUP, 22'h012345);
    chk8(8'(n_st), 8'h00, 8'hff);
    wr(`FCS_CMD_CONFIRM, 22'h012345);
    rd(22'h0, 8'h00, 8'h80);
    chk8(8'(n_st), 8'h01, 8'hff);
    chka(tgt, 22'h012345);
    wr(`FCS_CMD_READ_ARRAY);
    rd(22'h0, 8'h00, 8'h80);
    wait_rdy();
    rd(22'h0, 8'h80);
    $display("test erase done");
    for (int k = 0; k < 2; k++) begin
      fail_next <= k[0];
      wr(k ? `FCS_CMD_PROG_SETUP_B : `FCS_CMD_PROG_SETUP_A);
      wr(8'h96 + 8'(k), 22'h000200 + 22'(k));
      rd(22'h0, 8'h00, 8'h80);
      chka(tgt, 22'h000200 + 22'(k));
      chk8(wval, 8'h96 + 8'(k), 8'hff);
      chk8(8'(n_st), 8'(k + 2), 8'hff);
      wait_rdy();
      rd(22'h0, k ? 8'h90 : 8'h80);
    end
    fail_next <= 1'b0;
    wr(`FCS_CMD_READ_STATUS);
    rd(22'h0, 8'h90);
    wr(`FCS_CMD_CLEAR_STATUS);
    wr(`FCS_CMD_READ_STATUS);
    rd(22'h0, 8'h80);
    wr(`FCS_CMD_ERASE_SETUP);
    wr(`FCS_CMD_READ_ARRAY);
    rd(22'h0, 8'hb0);
    $display("test program done");
    // lock bit, top pin, other pin, then low voltage
    for (int k = 0; k < 4; k++) begin
      lock <= (k == 0);
      in_top <= (k == 1);
      tbp_n <= (k != 1);
      wp_n <= (k != 2);
      vpp_hi <= (k != 3);
      vpp_lk <= (k == 3);
      wr(`FCS_CMD_CLEAR_STATUS);
      wr(k == 3 ? `FCS_CMD_ERASE_SETUP : `FCS_CMD_PROG_SETUP_A);
      wr(k == 3 ? `FCS_CMD_CONFIRM : 8'h55);
      wr(`FCS_CMD_READ_STATUS);
      rd(22'h0, k == 3 ? 8'ha8 : 8'h92);
      chk8(8'(n_st), 8'h03, 8'hff);
      wr(`FCS_CMD_READ_IDENT);
      rd(22'h0, `FCS_IDENT_MAKER);
    end
    lock <= 1'b0;
    in_top <= 1'b0;
    tbp_n <= 1'b1;
    vpp_hi <= 1'b1;
    vpp_lk <= 1'b0;
    wr(`FCS_CMD_CLEAR_STATUS);
    $display("test refusals done");
    for (int k = 0; k < 2; k++) begin
      wr(k ? `FCS_CMD_PROG_SETUP_B : `FCS_CMD_ERASE_SETUP);
      wr(k ? 8'h11 : `FCS_CMD_CONFIRM);
      wr(`FCS_CMD_SUSPEND);
      wait_rdy();
      rd(22'h0, k ? 8'h84 : 8'hc0);
      wr(`FCS_CMD_CONFIRM);
      // paused flags follow the engine's level, two edges after the resume write
      repeat (2) @(posedge i_mclk);
      rd(22'h0, 8'h00, 8'hc4);
      wait_rdy();
      rd(22'h0, 8'h80);
    end
    chk8(8'(n_sr), 8'h04, 8'hff);
    $display("test suspend done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
